// File: hw/env_sensor_defines.svh
// Offsets, field positions, reset values and timing counts
// Assumes inclusion by bare name from the design files
`ifndef ENV_SENSOR_DEFINES_SVH
`define ENV_SENSOR_DEFINES_SVH
`define OFS_TEMP_LSB 8'h00
`define OFS_TEMP_MSB 8'h01
`define OFS_HUMID_LSB 8'h02
`define OFS_HUMID_MSB 8'h03
`define OFS_STATUS 8'h04
`define OFS_TEMP_PEAK 8'h05
`define OFS_HUMID_PEAK 8'h06
`define OFS_ALERT_EN 8'h07
`define OFS_TEMP_TRIM 8'h08
`define OFS_HUMID_TRIM 8'h09
`define OFS_TEMP_LOW 8'h0A
`define OFS_TEMP_HIGH 8'h0B
`define OFS_HUMID_LOW 8'h0C
`define OFS_HUMID_HIGH 8'h0D
`define OFS_RST_CFG 8'h0E
`define OFS_CONV_CFG 8'h0F
`define OFS_ID_FIRST 8'hFC
`define OFS_MAKER_LO 8'hFC
`define OFS_MAKER_HI 8'hFD
`define OFS_PART_LO 8'hFE
`define OFS_PART_HI 8'hFF
`define TGT_ADDR_LO 7'h40
`define TGT_ADDR_HI 7'h41
`define BIT_DRDY 7
`define BIT_HH 4
`define BIT_HL 3
`define BIT_SRST 7
`define BIT_RATE_HI 6
`define BIT_RATE_LO 4
`define BIT_PIN_EN 2
`define BIT_POL 1
`define BIT_MODE 0
`define BIT_TRIG 0
`define BIT_SEL_HI 2
`define BIT_SEL_LO 1
`define RST_ZERO 8'h00
`define RST_LIMIT_HI 8'hFF
`define CLK_PERIOD_NS 8
`define PWRUP_TIME_NS 3000000
`define AUTO_PERIOD_CYC 25000000
`endif

// File: hw/env_sensor_pkg.sv
// Types shared by the sensor target interface
// Assumes the defines header carries all numbers
package env_sensor_pkg;
   typedef enum logic [2:0] {
      I_IDLE, I_ADDR, I_PTR, I_WDATA, I_READ, I_ACK, I_RACK
   } bus_state_t;
   typedef enum logic {M_SLEEP, M_MEAS} meas_state_t;
endpackage

// File: hw/env_sensor_i2c_regs_alerts.sv
// Two-wire target, register file, sleep/measure sequencing and
// humidity alert flags of a humidity and temperature sensor.
// Assumes SCL/SDA/strap are asynchronous pins and the converter
// handshake (CONV_*, *_SAMPLE) runs on REF_CLK.
// Notes on behaviour
// - Humidity above high limit sets high flag
// - Humidity below low limit sets low flag
// - Comparator mode: flags follow latest conversion
// - Latched mode: flag holds until status read
// - Alert pin polarity chosen by config bit
// - Power-up lands in sleep mode
// - Trigger converts, stores results, returns to sleep
// - Target address 1000000 or 1000001 by strap
// - Ready for measurement within 3 ms
// - Acts only as bus target
// - Bytes shift most significant bit first
// - First written byte sets register pointer
// - Reads start at the register pointer
// - Pointer increments after every data byte
// - Writes to read-only registers get NACK
// - Unused pointer value gets NACK
// - Foreign target address gets no ACK
// - Peaks frozen during automatic measurement
// - Status read clears every flag
`include "env_sensor_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module env_sensor_i2c_regs_alerts
   import env_sensor_pkg::*;
#(
   parameter int PWRUP_CYC =
      (`PWRUP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
   parameter int AUTO_CYC = `AUTO_PERIOD_CYC,
   parameter logic [7:0] MAKER_LO = 8'hA5, // Arbitrary value
   parameter logic [7:0] MAKER_HI = 8'h5A, // Arbitrary value
   parameter logic [7:0] PART_LO = 8'h3C,  // Arbitrary value
   parameter logic [7:0] PART_HI = 8'hC3   // Arbitrary value
) (
   input wire logic REF_CLK,
   input wire logic SYS_RST,
   input wire logic SCL,
   input wire logic SDA_IN,
   output logic SDA_OUT,
   output logic SDA_OE,
   input wire logic ADDR_STRAP,
   input wire logic [15:0] TEMP_SAMPLE,
   input wire logic [15:0] HUMID_SAMPLE,
   input wire logic CONV_DONE,
   output logic CONV_REQ,
   output logic CONV_TEMP,
   output logic CONV_HUMID,
   output logic READY,
   output logic ALERT_OUT,
   output logic ALERT_OE
);

   // Pointer names a register that exists
   function automatic logic is_used(input logic [7:0] a);
      is_used = (a <= `OFS_CONV_CFG) || (a >= `OFS_ID_FIRST);
   endfunction

   // Pointer names a register software may write
   function automatic logic is_writable(input logic [7:0] a);
      is_writable = (a > `OFS_STATUS) && (a <= `OFS_CONV_CFG);
   endfunction

   // Pin synchronisers, third stage only for edge finding
   logic scl_s1, scl_s2, scl_s3;
   logic sda_s1, sda_s2, sda_s3;
   logic strap_s1, strap_s2;

   // Power-up and strap capture
   logic [31:0] pwr_cnt; // Cycles since reset release, holds once ready
   logic strap;          // Captured strap level

   // Bus engine state
   bus_state_t bstate;   // Current bus phase
   bus_state_t ret;      // Phase after the ack slot
   logic [3:0] cnt;      // Bits seen in this byte
   logic [7:0] sh;       // Receive shift register
   logic [7:0] tx;       // Transmit shift register
   logic [7:0] ptr;      // Register pointer
   logic ack_ok;         // Controller acked last read byte

   // Measurement sequencing
   meas_state_t mstate;  // Sleep or measuring
   logic [31:0] auto_cnt; // Periodic trigger timer

   // Register file
   logic [15:0] temp_res, humid_res;
   logic drdy_flag, humid_high_flag, humid_low_flag;
   logic [7:0] temp_peak, humid_peak, alert_enable;
   logic [7:0] temp_offset_trim, humid_offset_trim;
   logic [7:0] temp_low_limit, temp_high_limit;
   logic [7:0] humid_low_limit, humid_high_limit;
   logic [7:0] softreset_alert_config, conversion_config;
   logic [7:0] rd_data;  // Read multiplexer output

   // Edge and condition decode
   wire scl_rise = scl_s2 & ~scl_s3;
   wire scl_fall = ~scl_s2 & scl_s3;
   wire bus_start = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
   wire bus_stop = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;
   wire byte_end = scl_fall & (cnt == 4'h8);
   wire [6:0] own_addr = strap ? `TGT_ADDR_HI : `TGT_ADDR_LO;
   wire addr_hit = (sh[7:1] == own_addr);
   wire ld = scl_fall & ((bstate == I_ACK && ret == I_READ) ||
                         (bstate == I_RACK && ack_ok));
   wire st_rd = ld & (ptr == `OFS_STATUS);
   wire res_rd = ld & (ptr <= `OFS_HUMID_MSB);
   wire wr_pulse = byte_end & (bstate == I_WDATA) & is_writable(ptr);
   wire [7:0] ptr_inc = ptr + 8'h01;

   // Acknowledge decision and follow-on phase per byte
   logic ack_now;
   bus_state_t nxt;
   always_comb begin
      ack_now = 1'b0;
      nxt = I_IDLE;
      case (bstate)
         I_ADDR: begin
            ack_now = addr_hit;
            nxt = !addr_hit ? I_IDLE : (sh[0] ? I_READ : I_PTR);
         end
         I_PTR: begin
            ack_now = is_used(sh);
            nxt = ack_now ? I_WDATA : I_IDLE;
         end
         I_WDATA: begin
            ack_now = is_writable(ptr);
            nxt = I_WDATA;
         end
         default: begin
            ack_now = 1'b0;
            nxt = I_IDLE;
         end
      endcase
   end

   // Measurement controls
   wire ready_now = (pwr_cnt >= PWRUP_CYC - 1);
   wire auto_on = |softreset_alert_config[`BIT_RATE_HI:`BIT_RATE_LO];
   wire auto_tick = auto_on & (auto_cnt >= AUTO_CYC - 1);
   wire start = READY & (mstate == M_SLEEP) &
                (conversion_config[`BIT_TRIG] | auto_tick);
   wire done = (mstate == M_MEAS) & CONV_DONE;
   wire [1:0] sel = conversion_config[`BIT_SEL_HI:`BIT_SEL_LO];
   wire got_h = done & CONV_HUMID;
   wire got_t = done & CONV_TEMP;
   wire [7:0] h_msb = HUMID_SAMPLE[15:8];
   wire [7:0] t_msb = TEMP_SAMPLE[15:8];
   wire hh_hit = alert_enable[`BIT_HH] &
                 (h_msb > humid_high_limit);
   wire hl_hit = alert_enable[`BIT_HL] &
                 (h_msb < humid_low_limit);
   wire cmp_mode = softreset_alert_config[`BIT_MODE];
   wire srst = wr_pulse & (ptr == `OFS_RST_CFG) & sh[`BIT_SRST];

   // Flag next values: hardware set wins over read clear
   wire next_hh = cmp_mode ?
      (got_h ? hh_hit : humid_high_flag & ~st_rd) :
      (humid_high_flag & ~st_rd) | (got_h & hh_hit);
   wire next_hl = cmp_mode ?
      (got_h ? hl_hit : humid_low_flag & ~st_rd) :
      (humid_low_flag & ~st_rd) | (got_h & hl_hit);
   wire next_drdy = (drdy_flag & ~(st_rd | res_rd)) |
                    (done & alert_enable[`BIT_DRDY]);

   // Pin source by priority: high, low, then data ready
   wire pin_act = alert_enable[`BIT_HH] ? humid_high_flag :
                  alert_enable[`BIT_HL] ? humid_low_flag :
                  drdy_flag;
   wire next_alert = ~(pin_act ^ softreset_alert_config[`BIT_POL]);

   // Read multiplexer
   always_comb begin
      case (ptr)
         `OFS_TEMP_LSB: rd_data = temp_res[7:0];
         `OFS_TEMP_MSB: rd_data = temp_res[15:8];
         `OFS_HUMID_LSB: rd_data = humid_res[7:0];
         `OFS_HUMID_MSB: rd_data = humid_res[15:8];
         `OFS_STATUS: rd_data = {drdy_flag, 2'b00, humid_high_flag,
                                 humid_low_flag, 3'b000};
         `OFS_TEMP_PEAK: rd_data = temp_peak;
         `OFS_HUMID_PEAK: rd_data = humid_peak;
         `OFS_ALERT_EN: rd_data = alert_enable;
         `OFS_TEMP_TRIM: rd_data = temp_offset_trim;
         `OFS_HUMID_TRIM: rd_data = humid_offset_trim;
         `OFS_TEMP_LOW: rd_data = temp_low_limit;
         `OFS_TEMP_HIGH: rd_data = temp_high_limit;
         `OFS_HUMID_LOW: rd_data = humid_low_limit;
         `OFS_HUMID_HIGH: rd_data = humid_high_limit;
         `OFS_RST_CFG: rd_data = softreset_alert_config;
         `OFS_CONV_CFG: rd_data = conversion_config;
         `OFS_MAKER_LO: rd_data = MAKER_LO;
         `OFS_MAKER_HI: rd_data = MAKER_HI;
         `OFS_PART_LO: rd_data = PART_LO;
         `OFS_PART_HI: rd_data = PART_HI;
         default: rd_data = `RST_ZERO;
      endcase
   end

   // Two-flop synchronisers for the pins
   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         {scl_s1, scl_s2, scl_s3} <= 3'h7;
         {sda_s1, sda_s2, sda_s3} <= 3'h7;
         {strap_s1, strap_s2} <= 2'h0;
      end else begin
         {scl_s1, scl_s2, scl_s3} <= {SCL, scl_s1, scl_s2};
         {sda_s1, sda_s2, sda_s3} <= {SDA_IN, sda_s1, sda_s2};
         {strap_s1, strap_s2} <= {ADDR_STRAP, strap_s1};
      end
   end

   // Power-up timer; strap sampled until ready
   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         pwr_cnt <= 32'h0;
         READY <= 1'b0;
         strap <= 1'b0;
      end else begin
         if (!ready_now)
            pwr_cnt <= pwr_cnt + 32'h1;
         READY <= ready_now;
         if (!READY)
            strap <= strap_s2;
      end
   end

   // Bus engine: target only, never drives SCL
   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         bstate <= I_IDLE;
         ret <= I_IDLE;
         cnt <= 4'h0;
         sh <= 8'h00;
         tx <= 8'h00;
         ptr <= 8'h00;
         ack_ok <= 1'b0;
         SDA_OE <= 1'b0;
         SDA_OUT <= 1'b0;
      end else if (bus_start) begin
         // Start or repeated start
         bstate <= I_ADDR;
         cnt <= 4'h0;
         SDA_OE <= 1'b0;
      end else if (bus_stop) begin
         bstate <= I_IDLE;
         SDA_OE <= 1'b0;
      end else begin
         case (bstate)
            I_ADDR, I_PTR, I_WDATA: begin
               // Shift in, first bit is the most significant
               if (scl_rise && cnt != 4'h8) begin
                  sh <= {sh[6:0], sda_s2};
                  cnt <= cnt + 4'h1;
               end
               if (byte_end) begin
                  cnt <= 4'h0;
                  bstate <= I_ACK;
                  ret <= nxt;
                  SDA_OE <= ack_now;
                  if (bstate == I_PTR && ack_now)
                     ptr <= sh;
                  if (bstate == I_WDATA)
                     ptr <= ptr_inc;
               end
            end
            I_ACK: begin
               // Release after the ack clock, or load read data
               if (scl_fall) begin
                  bstate <= ret;
                  SDA_OE <= 1'b0;
                  if (ld) begin
                     tx <= rd_data;
                     SDA_OE <= ~rd_data[7];
                     ptr <= ptr_inc;
                     cnt <= 4'h0;
                  end
               end
            end
            I_READ: begin
               // Shift out on falling edges, count on rising
               if (scl_rise)
                  cnt <= cnt + 4'h1;
               if (scl_fall) begin
                  if (cnt == 4'h8) begin
                     SDA_OE <= 1'b0;
                     bstate <= I_RACK;
                  end else begin
                     tx <= {tx[6:0], 1'b0};
                     SDA_OE <= ~tx[6];
                  end
               end
            end
            I_RACK: begin
               // Controller ack continues, NACK ends the read
               if (scl_rise)
                  ack_ok <= ~sda_s2;
               if (scl_fall) begin
                  if (ld) begin
                     tx <= rd_data;
                     SDA_OE <= ~rd_data[7];
                     ptr <= ptr_inc;
                     cnt <= 4'h0;
                     bstate <= I_READ;
                  end else begin
                     bstate <= I_IDLE;
                  end
               end
            end
            default: begin
               // Idle: wait for a start
               SDA_OE <= 1'b0;
            end
         endcase
      end
   end

   // Sleep and measurement sequencing
   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         mstate <= M_SLEEP;
         CONV_REQ <= 1'b0;
         CONV_TEMP <= 1'b0;
         CONV_HUMID <= 1'b0;
         auto_cnt <= 32'h0;
      end else begin
         // Periodic timer runs only in automatic mode
         if (!auto_on || auto_tick)
            auto_cnt <= 32'h0;
         else
            auto_cnt <= auto_cnt + 32'h1;
         case (mstate)
            M_SLEEP: begin
               if (start) begin
                  mstate <= M_MEAS;
                  CONV_REQ <= 1'b1;
                  CONV_TEMP <= (sel != 2'b10);
                  CONV_HUMID <= (sel != 2'b01);
               end
            end
            M_MEAS: begin
               if (CONV_DONE) begin
                  mstate <= M_SLEEP;
                  CONV_REQ <= 1'b0;
               end
            end
            default: mstate <= M_SLEEP;
         endcase
      end
   end

   // Register file, results, peaks and flags
   always_ff @(posedge REF_CLK) begin
      if (SYS_RST || srst) begin
         temp_res <= 16'h0000;
         humid_res <= 16'h0000;
         drdy_flag <= 1'b0;
         humid_high_flag <= 1'b0;
         humid_low_flag <= 1'b0;
         temp_peak <= `RST_ZERO;
         humid_peak <= `RST_ZERO;
         alert_enable <= `RST_ZERO;
         temp_offset_trim <= `RST_ZERO;
         humid_offset_trim <= `RST_ZERO;
         temp_low_limit <= `RST_ZERO;
         temp_high_limit <= `RST_LIMIT_HI;
         humid_low_limit <= `RST_ZERO;
         humid_high_limit <= `RST_LIMIT_HI;
         softreset_alert_config <= `RST_ZERO;
         conversion_config <= `RST_ZERO;
      end else begin
         // Software writes
         if (wr_pulse) begin
            case (ptr)
               `OFS_TEMP_PEAK: temp_peak <= sh;
               `OFS_HUMID_PEAK: humid_peak <= sh;
               `OFS_ALERT_EN: alert_enable <= sh;
               `OFS_TEMP_TRIM: temp_offset_trim <= sh;
               `OFS_HUMID_TRIM: humid_offset_trim <= sh;
               `OFS_TEMP_LOW: temp_low_limit <= sh;
               `OFS_TEMP_HIGH: temp_high_limit <= sh;
               `OFS_HUMID_LOW: humid_low_limit <= sh;
               `OFS_HUMID_HIGH: humid_high_limit <= sh;
               `OFS_RST_CFG: softreset_alert_config <= sh;
               `OFS_CONV_CFG: conversion_config <= sh;
               default: ;
            endcase
         end
         // Trigger bit self-clears once taken
         if (start)
            conversion_config[`BIT_TRIG] <= 1'b0;
         // Store conversion results
         if (got_t)
            temp_res <= TEMP_SAMPLE;
         if (got_h)
            humid_res <= HUMID_SAMPLE;
         // Peaks only outside automatic mode
         if (got_t && !auto_on && t_msb > temp_peak)
            temp_peak <= t_msb;
         if (got_h && !auto_on && h_msb > humid_peak)
            humid_peak <= h_msb;
         drdy_flag <= next_drdy;
         humid_high_flag <= next_hh;
         humid_low_flag <= next_hl;
      end
   end

   // Alert pin, driven only when enabled
   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         ALERT_OUT <= 1'b0;
         ALERT_OE <= 1'b0;
      end else begin
         ALERT_OUT <= next_alert;
         ALERT_OE <= softreset_alert_config[`BIT_PIN_EN];
      end
   end

endmodule
`default_nettype wire

// File: bench/env_sensor_sva.sv
// Checker for the sensor target: power-up, converter handshake, pins
// Assumes it is bound onto the top module and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module env_sensor_sva #(
   parameter int PWRUP_CYC = 20
) (
   input wire logic REF_CLK,
   input wire logic SYS_RST,
   input wire logic SDA_OUT,
   input wire logic SDA_OE,
   input wire logic CONV_DONE,
   input wire logic CONV_REQ,
   input wire logic CONV_TEMP,
   input wire logic CONV_HUMID,
   input wire logic READY
);
   int unsigned age; // Cycles since reset release, saturating
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (SYS_RST);
   // Age counter, stops a little past the ready point
   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         age <= 0;
      end else if (age < PWRUP_CYC + 4) begin
         age <= age + 1;
      end
   end
   // Start of a measurement
   sequence conv_start;
      $rose(CONV_REQ);
   endsequence
   // Converter answering a standing request
   sequence conv_answer;
      CONV_REQ && CONV_DONE;
   endsequence
   a_ready_late: assert property (age == PWRUP_CYC + 4 |-> READY)
      else $error("ready came late");
   a_ready_stays: assert property (READY |=> READY)
      else $error("ready fell");
   a_wake_asleep: assert property ($fell(SYS_RST) |->
      !READY && !CONV_REQ && !SDA_OE)
      else $error("not asleep after reset");
   a_meas_ready: assert property (conv_start |-> READY)
      else $error("measurement before ready");
   a_conv_holds: assert property (CONV_REQ && !CONV_DONE |=> CONV_REQ)
      else $error("request dropped early");
   a_conv_sleeps: assert property (conv_answer |-> ##[1:2] !CONV_REQ)
      else $error("no return to sleep");
   a_conv_picks: assert property (conv_start |-> CONV_TEMP || CONV_HUMID)
      else $error("nothing selected");
   a_sel_steady: assert property (CONV_REQ && $past(CONV_REQ) |->
      $stable({CONV_TEMP, CONV_HUMID}))
      else $error("selection moved");
   a_sda_drain: assert property (SDA_OUT == 1'b0)
      else $error("data pin driven high");
endmodule
bind env_sensor_i2c_regs_alerts env_sensor_sva #(.PWRUP_CYC(PWRUP_CYC))
   i_env_sensor_sva (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST),
   .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .CONV_DONE(CONV_DONE),
   .CONV_REQ(CONV_REQ), .CONV_TEMP(CONV_TEMP), .CONV_HUMID(CONV_HUMID),
   .READY(READY));
`default_nettype wire

// File: bench/bus_ctrl_model.sv
// Two-wire bus controller model: drives SCL, pulls SDA low
// Assumes the bench resolves SDA with a pull-up; steps on clk edges
`timescale 1ns/1ps
`default_nettype none
module bus_ctrl_model (
   input wire logic clk,
   input wire logic sda_line,
   output logic scl,
   output logic sda_low
);
   // Bus idles with both lines released
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   // Waits some clock edges
   task automatic wait_clk(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Start or repeated start, leaves SCL low
   task automatic start_cond();
      sda_low <= 1'b0;
      wait_clk(3);
      scl <= 1'b1;
      wait_clk(4);
      sda_low <= 1'b1;
      wait_clk(4);
      scl <= 1'b0;
      wait_clk(3);
   endtask
   // Stop, leaves the bus idle
   task automatic stop_cond();
      sda_low <= 1'b1;
      wait_clk(3);
      scl <= 1'b1;
      wait_clk(4);
      sda_low <= 1'b0;
      wait_clk(4);
   endtask
   // One bit: set during SCL low, sample in mid high
   task automatic one_bit(input logic b, output logic r);
      sda_low <= ~b;
      wait_clk(3);
      scl <= 1'b1;
      wait_clk(2);
      r = sda_line;
      wait_clk(2);
      scl <= 1'b0;
      wait_clk(3);
   endtask
   // Byte then ninth bit; b9 high leaves SDA to the target
   task automatic xfer(input logic [7:0] tx, input logic b9,
      output logic [7:0] rx, output logic acked);
      logic r9;
      for (int i = 7; i >= 0; i--) begin
         one_bit(tx[i], rx[i]);
      end
      one_bit(b9, r9);
      acked = ~r9;
   endtask
endmodule
`default_nettype wire

// File: bench/env_sensor_i2c_regs_alerts_bench.sv
// Bench: register access, refusals, measurements and humidity alerts
// Assumes the controller model on the bus and a converter stand-in
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin comparisons++; \
   if ((got) !== (exp)) begin fail_count++; \
   $display("BAD %0t got %h expected %h", $time, got, exp); end end
module env_sensor_i2c_regs_alerts_bench;
   logic clk = 1'b0; // System clock
   logic rst = 1'b1; // Reset, high at start
   logic strap = 1'b0; // Address strap, drawn once
   logic conv_done = 1'b0; // Converter answer
   logic [15:0] temp_s = 16'h0000; // Temperature sample
   logic [15:0] humid_s = 16'h0000; // Humidity sample
   logic scl, sda_low, sda_out, sda_oe, conv_req, conv_temp, conv_humid;
   logic ready, alert_out, alert_oe, ack, pol, mode, hh;
   logic [1:0] sel_seen; // Selection seen at request
   logic [7:0] aw, rx, m, d;
   logic [7:0] rbuf [0:3];
   int fail_count = 0;
   int comparisons = 0;
   int cycles = 0;
   int seed = 76;
   wire sda_line = ~(sda_oe & ~sda_out) & ~sda_low; // Pull-up wire
   env_sensor_i2c_regs_alerts #(.PWRUP_CYC(20), .AUTO_CYC(50))
      i_env_sensor_i2c_regs_alerts (.REF_CLK(clk), .SYS_RST(rst),
      .SCL(scl), .SDA_IN(sda_line), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
      .ADDR_STRAP(strap), .TEMP_SAMPLE(temp_s), .HUMID_SAMPLE(humid_s),
      .CONV_DONE(conv_done), .CONV_REQ(conv_req), .CONV_TEMP(conv_temp),
      .CONV_HUMID(conv_humid), .READY(ready), .ALERT_OUT(alert_out),
      .ALERT_OE(alert_oe));
   // Sole target on this bus, so no address is shared
   bus_ctrl_model i_bus_ctrl_model (.clk(clk), .sda_line(sda_line),
      .scl(scl), .sda_low(sda_low));
   // Clock
   initial begin
      forever #4 clk = ~clk;
   end
   // Verdict and end of run
   task automatic test_done();
      if (fail_count == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // Expected humidity flags in status layout
   function automatic logic [7:0] flags(input logic [7:0] v);
      return {3'b000, v > 8'hC0, v < 8'h40, 3'b000};
   endfunction
   // Expected pin level for a flag
   function automatic logic pin(input logic p, input logic f);
      return p ? f : ~f;
   endfunction
   // One byte written, acknowledge checked
   task automatic send(input logic [7:0] b, input logic exp);
      i_bus_ctrl_model.xfer(b, 1'b1, rx, ack);
      `CHK(ack, exp)
   endtask
   // Start, own address, pointer byte
   task automatic open_ptr(input logic [7:0] p, input logic ok);
      i_bus_ctrl_model.start_cond();
      send(aw, 1'b1);
      send(p, ok);
   endtask
   // Single byte register write
   task automatic wr1(input logic [7:0] p, input logic [7:0] v);
      open_ptr(p, 1'b1);
      send(v, 1'b1);
      i_bus_ctrl_model.stop_cond();
   endtask
   // Pointer move then read of n bytes
   task automatic rd(input logic [7:0] p, input int n);
      open_ptr(p, 1'b1);
      i_bus_ctrl_model.start_cond();
      send(aw | 8'h01, 1'b1);
      for (int i = 0; i < n; i++) begin
         i_bus_ctrl_model.xfer(8'hFF, i == n - 1, rbuf[i], ack);
      end
      i_bus_ctrl_model.stop_cond();
   endtask
   // New samples then a triggered conversion
   task automatic meas(input logic [7:0] hm, input logic [1:0] sel);
      logic [15:0] r;
      r = 16'($random(seed));
      @(posedge clk);
      humid_s <= {hm, r[7:0]};
      temp_s <= r;
      wr1(8'h0F, {5'h00, sel, 1'b1});
   endtask
   // Converter stand-in and run limit
   always @(posedge clk) begin
      conv_done <= conv_req & ~conv_done;
      if (conv_req & ~conv_done) begin
         sel_seen <= {conv_temp, conv_humid};
      end
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         fail_count++;
         test_done();
      end
   end
   // Main sequence
   initial begin
      strap = 1'($random(seed));
      aw = {6'h20, strap, 1'b0};
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      i_bus_ctrl_model.start_cond();
      send(aw ^ 8'h02, 1'b0);
      i_bus_ctrl_model.stop_cond();
      rd(8'h0A, 4);
      `CHK({rbuf[0], rbuf[1], rbuf[2], rbuf[3]}, 32'h00FF00FF)
      open_ptr(8'h10 + 8'($unsigned($random(seed)) % 236), 1'b0);
      i_bus_ctrl_model.stop_cond();
      d = 8'($random(seed));
      open_ptr(8'h03, 1'b1);
      send(~d, 1'b0);
      send(d, 1'b0);
      send(d, 1'b1);
      i_bus_ctrl_model.stop_cond();
      open_ptr(8'hFC, 1'b1);
      send(d, 1'b0);
      i_bus_ctrl_model.stop_cond();
      rd(8'h05, 1);
      `CHK(rbuf[0], d)
      for (int i = 0; i < 100 && ready !== 1'b1; i++) @(posedge clk);
      `CHK(ready, 1'b1)
      for (int s = 0; s < 4; s++) begin
         meas(8'h80, 2'(s));
         `CHK(sel_seen, (s == 1) ? 2'b10 : (s == 2) ? 2'b01 : 2'b11)
      end
      wr1(8'h0C, 8'h40);
      wr1(8'h0D, 8'hC0);
      wr1(8'h07, 8'h18);
      for (int k = 0; k < 4; k++) begin
         {pol, mode} = 2'(k);
         wr1(8'h0E, {5'h01, pol, mode});
         m = 8'hC1 + 8'($unsigned($random(seed)) % 63);
         meas(m, 2'b00);
         `CHK({alert_oe, alert_out}, {1'b1, pin(pol, 1'b1)})
         m = 8'h40 + 8'($unsigned($random(seed)) % 129);
         meas(m, 2'b00);
         hh = ~mode;
         `CHK(alert_out, pin(pol, hh))
         rd(8'h02, 2);
         `CHK({rbuf[1], rbuf[0]}, humid_s)
         rd(8'h04, 1);
         `CHK(rbuf[0] & 8'h18, {3'b000, hh, 4'h0})
         rd(8'h04, 1);
         `CHK(rbuf[0] & 8'h18, 8'h00)
         `CHK(alert_out, pin(pol, 1'b0))
         m = 8'($unsigned($random(seed)) % 64);
         meas(m, 2'b00);
         rd(8'h04, 1);
         `CHK(rbuf[0] & 8'h18, flags(m))
      end
      // Soft reset brings the limits back to their reset values
      wr1(8'h0E, 8'h80);
      rd(8'h0C, 2);
      `CHK({rbuf[0], rbuf[1]}, 16'h00FF)
      // Automatic mode: results refresh, peak stays frozen
      @(posedge clk);
      humid_s <= 16'hFF00;
      wr1(8'h0E, 8'h10);
      rd(8'h03, 1);
      `CHK(rbuf[0], 8'hFF)
      rd(8'h06, 1);
      `CHK(rbuf[0], 8'h00)
      test_done();
   end
endmodule
`default_nettype wire
